/* File: rtcnv_pkg.sv */
/*
 Shared constants and types for the two-wire clock/calendar and byte memory core.
 Assumes one 100 MHz clock, a synchronous active-high reset and an APB master.
*/
// Summary of operation
// R1: alarm mode pulls shared output low
// R2: calibration mode drives 512 Hz wave
// R3: wave mode selects 1/512/4096/32768 Hz
// R4: send after SCL fall, sample on rise
// R5: memory and clock answer separate identifiers
// R6: clock accesses keep memory pointer intact
// R7: clock target holds fifteen registers
// R8: memory holds 8192 eight-bit bytes
// R9: memory writes need no wait
// R10: two protect bits choose protected range
// R11: protected byte not stored, not acknowledged
// R12: protect bits cleared when backup absent
// R13: time-base divided to one-second tick
// R14: seconds through year readable and writable
// R15: BCD calendar with leap years to 2099
// R16: snapshot bit rise copies core time
// R17: pending tick applied before snapshot copy
// R18: holding registers frozen while snapshot set
// R19: lock bit freezes; clearing loads core
// R20: master never loads invalid time values
// R21: master initialises time after low-backup
// R22: charge enable bit drives charge output
// R23: fast-charge bit raises charge current
// R24: calibration bit dedicates shared output
// R25: alarm sets flag; reading clears it
// R26: no mode leaves shared output released; code releases it in alarm mode unless flag and enable are both set
package rtcnv_pkg;
   // APB byte addresses.
   localparam logic [7:0] APB_PWR  = 8'h00;
   localparam logic [7:0] APB_STAT = 8'h04;
   // Clock target register indices.
   localparam logic [3:0] R_CTL    = 4'h0;
   localparam logic [3:0] R_CALV   = 4'h1;
   localparam logic [3:0] R_LAST   = 4'he;
   localparam int         NUM_REGS = 15;
   // Control register 00 fields.
   localparam int CTL_SNAP = 0;
   localparam int CTL_LOCK = 1;
   localparam int CTL_CAL  = 2;
   localparam int CTL_FS   = 4;
   localparam int CTL_AF   = 6;
   localparam int CTL_LB   = 7;
   // Configuration register 0E fields.
   localparam int CFG_FC  = 1;
   localparam int CFG_VBC = 2;
   localparam int CFG_WP  = 3;
   localparam int CFG_SQW = 5;
   localparam int CFG_AEN = 6;
   // Default bus identifiers (7-bit).
   localparam logic [6:0] MEM_ID_DEF = 7'h50;
   localparam logic [6:0] RTC_ID_DEF = 7'h68;
   // Memory geometry.
   localparam int MEM_DEPTH = 8192;
   localparam int MEM_AW    = 13;
   // Divider of the 32768 Hz time-base and its wave taps.
   localparam int DIV_W    = 15;
   localparam int TAP_1HZ  = 14;
   localparam int TAP_512  = 5;
   localparam int TAP_4096 = 2;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rtcnv_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } rtcnv_apb_rsp_t;

   typedef enum logic [2:0] {TW_IDLE, TW_DEV, TW_ABYTE, TW_WR, TW_RD, TW_ACK,
                             TW_RACK} rtcnv_tw_t;
endpackage : rtcnv_pkg

/* File: rtcnv_core.sv */
/*
 Calendar clock with alarm, wave output and an 8192-byte memory, reached over
 a two-wire serial bus as two targets, plus a small APB status port.
 Assumes SCL, SDA and the time-base arrive asynchronously and are far slower
 than clk_i; open-drain pins are resolved outside.
*/
`timescale 1ns/1ps
module rtcnv_core
   import rtcnv_pkg::*;
#(
   parameter logic [6:0] MEM_ID = rtcnv_pkg::MEM_ID_DEF,
   parameter logic [6:0] RTC_ID = rtcnv_pkg::RTC_ID_DEF,
   parameter int         DEPTH  = rtcnv_pkg::MEM_DEPTH,
   parameter int         AW     = rtcnv_pkg::MEM_AW
)(
   input  wire logic                      clk_i,           // System clock.
   input  wire logic                      reset_i,         // Sync reset.
   input  wire rtcnv_pkg::rtcnv_apb_req_t apb_i,           // APB request.
   output rtcnv_pkg::rtcnv_apb_rsp_t      apb_o,           // APB answer.
   input  wire logic                      scl_i,           // Serial clock.
   input  wire logic                      sda_i,           // Serial data in.
   output logic                           sda_drive_n_o,   // Low pulls SDA.
   input  wire logic                      timebase_in_i,   // 32768 Hz.
   output logic                           alarm_cal_wave_out_drive_n_o, // Low pulls.
   output logic                           backup_charge_enable_o, // Charge on.
   output logic                           fast_charge_select_o    // Fast charge.
);
   // Refuse parameter sets the decoder cannot serve.
   if (MEM_ID == RTC_ID || DEPTH != (1 << AW) || AW < 8 || AW > 16)
   begin : g_bad
      $error("rtcnv_core: bad identifiers or memory geometry");
   end

   typedef struct packed {
      logic [2:0]       scl_s;
      logic [2:0]       sda_s;
      logic [2:0]       tb_s;
      logic             scl_f;
      logic             sda_f;
      logic             tb_f;
      logic [DIV_W-1:0] div;
      logic [6:0][7:0]  core;
      logic [NUM_REGS-1:0][7:0] regs;
      rtcnv_tw_t        st;
      rtcnv_tw_t        st_nx;
      logic [3:0]       bcnt;
      logic [7:0]       sh;
      logic             rtc_sel;
      logic             first_ab;
      logic [AW-1:0]    mptr;
      logic [3:0]       rptr;
      logic             sda_n;
      logic             acs_n;
      logic             backup_charge_enable;
      logic             fc;
      rtcnv_apb_rsp_t   rsp;
   } rtcnv_st_t;

   rtcnv_st_t q_r;
   rtcnv_st_t q_nxt;
   logic [7:0] mem [DEPTH];
   logic          mem_we;
   logic [7:0]    rd_byte;
   logic          scl_rise, scl_fall, start_c, stop_c, tb_rise, tick;
   logic          do_load, prot, snap_rise, lock_fall, match, acs_lvl;
   logic [6:0][7:0] c;
   logic [8:0]    t;
   logic [1:0]    wp;
   logic [7:0]    v;

   // BCD increment with wrap; bit 8 is the carry into the next field.
   function automatic logic [8:0] bcd_inc(input logic [7:0] val,
                                         input logic [7:0] last,
                                         input logic [7:0] first);
      if (val == last)
         return {1'b1, first};
      else if (val[3:0] == 4'h9)
         return {1'b0, val[7:4] + 4'h1, 4'h0};
      else
         return {1'b0, val[7:4], val[3:0] + 4'h1};
   endfunction : bcd_inc

   // Last date of a month; the divisible-by-four rule holds up to 2099.
   function automatic logic [7:0] month_last(input logic [7:0] mon,
                                            input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == 8'h02)
         return leap ? 8'h29 : 8'h28;
      else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
         return 8'h30;
      else
         return 8'h31;
   endfunction : month_last

   // Next-state logic for the whole block.
   always_comb
   begin
      q_nxt     = q_r;
      mem_we    = 1'b0;
      do_load   = 1'b0;
      v         = 8'h00;
      t         = 9'h000;
      // Pin inputs: a level counts once the second and third stages agree.
      q_nxt.scl_s = {q_r.scl_s[1:0], scl_i};
      q_nxt.sda_s = {q_r.sda_s[1:0], sda_i};
      q_nxt.tb_s  = {q_r.tb_s[1:0], timebase_in_i};
      if (q_r.scl_s[1] == q_r.scl_s[2])
         q_nxt.scl_f = q_r.scl_s[2];
      if (q_r.sda_s[1] == q_r.sda_s[2])
         q_nxt.sda_f = q_r.sda_s[2];
      if (q_r.tb_s[1] == q_r.tb_s[2])
         q_nxt.tb_f = q_r.tb_s[2];
      scl_rise = q_nxt.scl_f & ~q_r.scl_f;
      scl_fall = ~q_nxt.scl_f & q_r.scl_f;
      start_c  = q_r.scl_f & q_nxt.scl_f & q_r.sda_f & ~q_nxt.sda_f;
      stop_c   = q_r.scl_f & q_nxt.scl_f & ~q_r.sda_f & q_nxt.sda_f;
      tb_rise  = q_nxt.tb_f & ~q_r.tb_f;

      // R13: one-second tick
      if (tb_rise)
         q_nxt.div = q_r.div + 1'b1;
      tick = tb_rise & (&q_r.div);

      // R10: protected range decode
      wp   = q_r.regs[R_LAST][CFG_WP +: 2];
      prot = (wp == 2'b11) | ((wp == 2'b10) & ~q_r.mptr[AW-1]) |
             ((wp == 2'b01) & (q_r.mptr[AW-1 -: 2] == 2'b00));
      // R6: each target keeps its own pointer
      rd_byte = q_r.rtc_sel ? q_r.regs[q_r.rptr] : mem[q_r.mptr];

      // Two-wire target engine.
      if (start_c)
      begin
         q_nxt.st    = TW_DEV;
         q_nxt.bcnt  = 4'h0;
         q_nxt.sda_n = 1'b1;
      end
      else if (stop_c)
      begin
         q_nxt.st    = TW_IDLE;
         q_nxt.sda_n = 1'b1;
      end
      // R4: sample on rising SCL
      else if (scl_rise)
      begin
         case (q_r.st)
            TW_DEV, TW_ABYTE, TW_WR:
               if (q_r.bcnt < 4'h8)
               begin
                  q_nxt.sh   = {q_r.sh[6:0], q_r.sda_f};
                  q_nxt.bcnt = q_r.bcnt + 4'h1;
               end
            TW_RACK:
               if (q_r.sda_f)
                  q_nxt.st = TW_IDLE;
            default:
               q_nxt.st = q_r.st;
         endcase
      end
      // R4: drive after falling SCL
      else if (scl_fall)
      begin
         case (q_r.st)
            TW_DEV:
               if (q_r.bcnt == 4'h8)
               begin
                  q_nxt.st_nx    = q_r.sh[0] ? TW_RD : TW_ABYTE;
                  q_nxt.first_ab = 1'b1;
                  // R5: two bus identifiers
                  if (q_r.sh[7:1] == MEM_ID || q_r.sh[7:1] == RTC_ID)
                  begin
                     q_nxt.rtc_sel = (q_r.sh[7:1] == RTC_ID);
                     q_nxt.sda_n   = 1'b0;
                     q_nxt.st      = TW_ACK;
                  end
                  else
                     q_nxt.st = TW_IDLE;
               end
            TW_ABYTE:
               if (q_r.bcnt == 4'h8)
               begin
                  q_nxt.sda_n = 1'b0;
                  q_nxt.st    = TW_ACK;
                  q_nxt.st_nx = TW_WR;
                  if (q_r.rtc_sel)
                     q_nxt.rptr = (q_r.sh[3:0] > R_LAST) ? R_CTL : q_r.sh[3:0];
                  else if (q_r.first_ab)
                  begin
                     q_nxt.mptr[AW-1:8] = q_r.sh[AW-9:0];
                     q_nxt.first_ab     = 1'b0;
                     q_nxt.st_nx        = TW_ABYTE;
                  end
                  else
                     q_nxt.mptr[7:0] = q_r.sh;
               end
            TW_WR:
               if (q_r.bcnt == 4'h8)
               begin
                  q_nxt.st_nx = TW_WR;
                  if (q_r.rtc_sel)
                  begin
                     // R7: fifteen-register bank
                     v = q_r.sh;
                     if (q_r.rptr == R_CTL)
                        v[CTL_AF] = q_r.regs[R_CTL][CTL_AF];
                     // R14: time registers writable
                     if (q_r.rptr != R_CALV || q_r.regs[R_CTL][CTL_CAL])
                        q_nxt.regs[q_r.rptr] = v;
                     q_nxt.rptr  = (q_r.rptr == R_LAST) ? R_CTL : q_r.rptr + 4'h1;
                     q_nxt.sda_n = 1'b0;
                     q_nxt.st    = TW_ACK;
                  end
                  // R11: protected byte refused
                  else if (prot)
                     q_nxt.st = TW_IDLE;
                  else
                  begin
                     // R9: store at once
                     mem_we      = 1'b1;
                     q_nxt.mptr  = q_r.mptr + 1'b1;
                     q_nxt.sda_n = 1'b0;
                     q_nxt.st    = TW_ACK;
                  end
               end
            TW_ACK:
            begin
               q_nxt.sda_n = 1'b1;
               q_nxt.bcnt  = 4'h0;
               q_nxt.st    = q_r.st_nx;
               do_load     = (q_r.st_nx == TW_RD);
            end
            TW_RD:
               if (q_r.bcnt == 4'h8)
               begin
                  q_nxt.sda_n = 1'b1;
                  q_nxt.st    = TW_RACK;
               end
               else
               begin
                  q_nxt.sda_n = q_r.sh[6];
                  q_nxt.sh    = {q_r.sh[6:0], 1'b0};
                  q_nxt.bcnt  = q_r.bcnt + 4'h1;
               end
            TW_RACK:
               do_load = 1'b1;
            default:
               q_nxt.st = q_r.st;
         endcase
      end

      // Fetch the next read byte and advance the active pointer only.
      if (do_load)
      begin
         q_nxt.st    = TW_RD;
         q_nxt.sh    = rd_byte;
         q_nxt.sda_n = rd_byte[7];
         q_nxt.bcnt  = 4'h1;
         if (q_r.rtc_sel)
         begin
            // R25: reading control clears flag
            if (q_r.rptr == R_CTL)
               q_nxt.regs[R_CTL][CTL_AF] = 1'b0;
            q_nxt.rptr = (q_r.rptr == R_LAST) ? R_CTL : q_r.rptr + 4'h1;
         end
         else
            q_nxt.mptr = q_r.mptr + 1'b1;
      end

      // Power events reported over APB; answer one cycle into the access.
      q_nxt.rsp = '0;
      if (apb_i.psel && apb_i.penable && !q_r.rsp.pready)
      begin
         q_nxt.rsp.pready = 1'b1;
         if (apb_i.paddr == APB_STAT)
            q_nxt.rsp.prdata = {7'h00, (q_r.st != TW_IDLE), wp,
                                q_r.regs[R_CTL][CTL_LB], q_r.regs[R_CTL][CTL_AF],
                                q_r.core[2][5:0], q_r.core[1][6:0], q_r.core[0][6:0]};
         else if (apb_i.paddr != APB_PWR)
            q_nxt.rsp.pslverr = 1'b1;
      end
      // A power write lands only at the edge that sees pready high, as the master expects.
      // R12: no backup clears protection
      if (apb_i.psel && apb_i.penable && apb_i.pwrite && q_r.rsp.pready &&
          apb_i.paddr == APB_PWR)
      begin
         if (apb_i.pwdata[0])
         begin
            q_nxt.regs[R_LAST][CFG_WP +: 2] = 2'b00;
            q_nxt.regs[R_CTL][CTL_LB]       = 1'b1;
         end
         if (apb_i.pwdata[1])
            q_nxt.regs[R_CTL][CTL_LB] = 1'b1;
      end

      // R15: BCD calendar chain
      c = q_r.core;
      if (tick)
      begin
         t = bcd_inc(c[0], 8'h59, 8'h00);
         c[0] = t[7:0];
         if (t[8])
         begin
            t = bcd_inc(c[1], 8'h59, 8'h00);
            c[1] = t[7:0];
            if (t[8])
            begin
               t = bcd_inc(c[2], 8'h23, 8'h00);
               c[2] = t[7:0];
               if (t[8])
               begin
                  t = bcd_inc(c[3], 8'h07, 8'h01);
                  c[3] = t[7:0];
                  t = bcd_inc(c[4], month_last(c[5], c[6]), 8'h01);
                  c[4] = t[7:0];
                  if (t[8])
                  begin
                     t = bcd_inc(c[5], 8'h12, 8'h01);
                     c[5] = t[7:0];
                     if (t[8])
                     begin
                        t = bcd_inc(c[6], 8'h99, 8'h00);
                        c[6] = t[7:0];
                     end
                  end
               end
            end
         end
      end
      // R19: lock release loads core
      lock_fall = q_r.regs[R_CTL][CTL_LOCK] & ~q_nxt.regs[R_CTL][CTL_LOCK];
      if (lock_fall)
         c = q_r.regs[8:2];
      q_nxt.core = c;

      // R17: holding takes ticked core
      snap_rise = ~q_r.regs[R_CTL][CTL_SNAP] & q_nxt.regs[R_CTL][CTL_SNAP];
      // R16: snapshot on rising bit
      if (snap_rise)
         q_nxt.regs[8:2] = c;
      // R18: frozen while snapshot or lock set
      else if (!q_nxt.regs[R_CTL][CTL_SNAP] && !q_nxt.regs[R_CTL][CTL_LOCK])
         q_nxt.regs[8:2] = c;

      // R25: alarm match sets flag
      match = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         if (i != 3 && !q_r.regs[9 + (i > 3 ? i - 1 : i)][7] &&
             q_r.regs[9 + (i > 3 ? i - 1 : i)][6:0] != c[i][6:0])
            match = 1'b0;
      end
      if (tick && match)
         q_nxt.regs[R_CTL][CTL_AF] = 1'b1;

      // R3: wave rate select
      case (q_r.regs[R_CTL][CTL_FS +: 2])
         2'b00:   acs_lvl = q_r.div[TAP_1HZ];
         2'b01:   acs_lvl = q_r.div[TAP_512];
         2'b10:   acs_lvl = q_r.div[TAP_4096];
         default: acs_lvl = q_r.tb_f;
      endcase
      // R24: calibration owns the output
      if (q_r.regs[R_CTL][CTL_CAL])
         // R2: 512 Hz tone
         q_nxt.acs_n = q_r.div[TAP_512];
      else if (q_r.regs[R_LAST][CFG_SQW])
         q_nxt.acs_n = acs_lvl;
      else
         // R1: alarm pulls low
         // R26: otherwise released
         q_nxt.acs_n = ~(q_r.regs[R_CTL][CTL_AF] & q_r.regs[R_LAST][CFG_AEN]);

      // R22: charge enable
      q_nxt.backup_charge_enable = q_r.regs[R_LAST][CFG_VBC];
      // R23: fast charge select
      q_nxt.fc  = q_r.regs[R_LAST][CFG_VBC] & q_r.regs[R_LAST][CFG_FC];
   end

   // R8: byte array, written at bus speed.
   always_ff @(posedge clk_i)
   begin
      if (mem_we)
         mem[q_r.mptr] <= q_r.sh;
   end

   // State register; pins start released and the line sync starts idle-high.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         q_r       <= '0;
         q_r.scl_s <= 3'b111;
         q_r.sda_s <= 3'b111;
         q_r.scl_f <= 1'b1;
         q_r.sda_f <= 1'b1;
         q_r.sda_n <= 1'b1;
         q_r.acs_n <= 1'b1;
      end
      else
         q_r <= q_nxt;
   end

   // Outputs come straight from the state register.
   assign apb_o                        = q_r.rsp;
   assign sda_drive_n_o                = q_r.sda_n;
   assign alarm_cal_wave_out_drive_n_o = q_r.acs_n;
   assign backup_charge_enable_o       = q_r.backup_charge_enable;
   assign fast_charge_select_o         = q_r.fc;
endmodule : rtcnv_core

/* File: rtcnv_core_sva.sv */
/*
 Concurrent checks on the ports of the two-wire clock/memory core.
 Assumes one clock domain, a synchronous active-high reset and the APB port.
*/
`timescale 1ns/1ps
module rtcnv_core_sva
   import rtcnv_pkg::*;
(
   input wire logic                      clk_i,                        // Clock.
   input wire logic                      reset_i,                      // Reset.
   input wire rtcnv_pkg::rtcnv_apb_req_t apb_i,                        // Request.
   input wire rtcnv_pkg::rtcnv_apb_rsp_t apb_o,                        // Answer.
   input wire logic                      scl_i,                        // Serial clock.
   input wire logic                      sda_drive_n_o,                // Data pull.
   input wire logic                      alarm_cal_wave_out_drive_n_o, // Shared pin.
   input wire logic                      backup_charge_enable_o,       // Charge.
   input wire logic                      fast_charge_select_o          // Fast.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic acc;
   logic mapped;
   // First access-phase edge, and whether the address decodes.
   assign acc    = apb_i.psel && apb_i.penable && !apb_o.pready;
   assign mapped = (apb_i.paddr == APB_PWR) || (apb_i.paddr == APB_STAT);

   a_apb_one_wait:  assert property (acc |=> apb_o.pready)
      else $error("answer late");
   a_ready_pulse:   assert property (apb_o.pready |=> !apb_o.pready)
      else $error("ready held");
   a_unmapped_err:  assert property (acc && !mapped |=> apb_o.pslverr &&
      apb_o.prdata == 32'h0)
      else $error("no error answer");
   a_mapped_ok:     assert property (acc && mapped |=> !apb_o.pslverr)
      else $error("false error");
   a_sda_after_fall: assert property ($changed(sda_drive_n_o) |-> !scl_i)
      else $error("data moved while clock high");
   a_ack_held_high: assert property (!sda_drive_n_o && $rose(scl_i) |=> !sda_drive_n_o [*3])
      else $error("driven bit dropped early");
   a_fast_needs_chg: assert property (fast_charge_select_o |-> backup_charge_enable_o)
      else $error("fast charge without enable");
   a_reset_quiet:   assert property ($fell(reset_i) |-> sda_drive_n_o &&
      alarm_cal_wave_out_drive_n_o && !backup_charge_enable_o && !fast_charge_select_o)
      else $error("pins active after reset");

   // Main scenarios reached by the bench.
   c_err:  cover property (apb_o.pslverr);
   c_ack:  cover property (!sda_drive_n_o);
   c_wave: cover property ($fell(alarm_cal_wave_out_drive_n_o));
   c_fast: cover property (fast_charge_select_o);
endmodule : rtcnv_core_sva

bind rtcnv_core rtcnv_core_sva u_sva (
   .clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i), .apb_o(apb_o), .scl_i(scl_i),
   .sda_drive_n_o(sda_drive_n_o),
   .alarm_cal_wave_out_drive_n_o(alarm_cal_wave_out_drive_n_o),
   .backup_charge_enable_o(backup_charge_enable_o),
   .fast_charge_select_o(fast_charge_select_o));

/* File: rtcnv_tw_master.sv */
/*
 Behavioural two-wire bus master that plays the host processor.
 Assumes a pull-up on the data wire; each clock phase lasts eight system clocks.
*/
`timescale 1ns/1ps
module rtcnv_tw_master (
   input  wire logic clk_i, // Paces the bit timing.
   input  wire logic sda_i, // Resolved data wire.
   output logic      scl_o, // Serial clock, high while idle.
   output logic      sda_o  // Data drive, 1 releases the wire.
);
   // Both lines rest released, so the clock stands still between frames.
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic gap(input int n);
      repeat (n) @(posedge clk_i);
   endtask : gap

   // Also serves as repeated start; the long first gap lets an ack drain.
   task automatic start;
      sda_o <= 1'b1;
      gap(8);
      scl_o <= 1'b1;
      gap(8);
      sda_o <= 1'b0;
      gap(8);
      scl_o <= 1'b0;
   endtask : start

   task automatic stop;
      gap(4);
      sda_o <= 1'b0;
      gap(4);
      scl_o <= 1'b1;
      gap(8);
      sda_o <= 1'b1;
      gap(8);
   endtask : stop

   task automatic xbyte(input logic [7:0] b, input logic mack, output logic [7:0] d,
                        output logic ack);
      logic [8:0] o;
      logic [8:0] s;
      o = {b, mack};
      for (int i = 8; i >= 0; i--)
      begin
         gap(4);
         sda_o <= o[i];
         gap(4);
         scl_o <= 1'b1;
         gap(6);
         s[i] = sda_i;
         gap(2);
         scl_o <= 1'b0;
      end
      d   = s[8:1];
      ack = !s[0];
   endtask : xbyte
endmodule : rtcnv_tw_master

/* File: test_rtcnv_core.sv */
/*
 Self-checking bench for the clock/memory core: serial and APB sequences.
 Assumes the partner master model and a pulled-up shared pin and data wire.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module test_rtcnv_core;
   import rtcnv_pkg::*;
   localparam logic [7:0] MW = {MEM_ID_DEF, 1'b0};
   localparam logic [7:0] RW = {RTC_ID_DEF, 1'b0};
   logic           clk_i, reset_i, timebase_in_i, scl, sda_m, sda_w;
   logic           sda_dn, acs_n, chg, fast, err;
   rtcnv_apb_req_t apb_i;
   rtcnv_apb_rsp_t apb_o;
   logic [7:0]     tx[$];
   logic [7:0]     rx[4];
   logic [7:0]     acks;
   logic [7:0]     shadow[3];
   logic [15:0]    ends[3] = '{16'h07ff, 16'h0fff, 16'h1fff};
   int             per[4]  = '{0, 512, 64, 8};
   logic [31:0]    rd;
   int             err_count, comparisons, c;

   // Open-drain data wire: low while either side pulls.
   assign sda_w = sda_m & sda_dn;
   rtcnv_core dut (.clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i), .apb_o(apb_o),
      .scl_i(scl), .sda_i(sda_w), .sda_drive_n_o(sda_dn), .timebase_in_i(timebase_in_i),
      .alarm_cal_wave_out_drive_n_o(acs_n), .backup_charge_enable_o(chg),
      .fast_charge_select_o(fast));
   rtcnv_tw_master u_mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

   // Clocks; the time-base is offset so it never lands on a system edge.
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      timebase_in_i = 1'b0;
      #3;
      forever #40 timebase_in_i = ~timebase_in_i;
   end

   task automatic complete_run;
      $display("err_count %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // One frame: id, tx bytes, then an optional read of nrd bytes.
   task automatic tw_tx(input logic [7:0] id, input int nrd);
      logic a;
      logic [7:0] d;
      u_mst.start();
      if (tx.size() > 0 || nrd == 0)
      begin
         u_mst.xbyte(id, 1'b1, d, acks[0]);
         foreach (tx[i])
            u_mst.xbyte(tx[i], 1'b1, d, acks[i + 1]);
         if (nrd > 0)
            u_mst.start();
      end
      if (nrd > 0)
         u_mst.xbyte(id | 8'h01, 1'b1, d, a);
      for (int i = 0; i < nrd; i++)
         u_mst.xbyte(8'hff, 1'(i == nrd - 1), rx[i], a);
      u_mst.stop();
   endtask : tw_tx

   task automatic rw(input logic [7:0] idx, input logic [7:0] v);
      tx = '{idx, v};
      tw_tx(RW, 0);
   endtask : rw

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      apb_i <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_i);
      apb_i.penable <= 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         @(posedge clk_i);
         if (apb_o.pready === 1'b1)
         begin
            rd = apb_o.prdata;
            err = apb_o.pslverr;
            apb_i <= '0;
            return;
         end
      end
      err_count++;
      complete_run();
   endtask : apb

   // Clocks between two falls of the shared pin, bounded.
   task automatic period;
      logic last;
      for (int k = 0; k < 2; k++)
      begin
         last = acs_n;
         for (c = 1; c < 2000; c++)
         begin
            @(posedge clk_i);
            if (last && !acs_n)
               break;
            last = acs_n;
         end
         if (c >= 2000)
         begin
            err_count++;
            complete_run();
         end
      end
   endtask : period

   // Main sequence.
   initial
   begin
      reset_i = 1'b1;
      apb_i = '0;
      err_count = 0;
      comparisons = 0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK(acs_n, 1'b1)
      tx = '{8'h00};
      tw_tx(8'h20, 0);
      `CHK(acks[0], 1'b0)
      tx = '{8'h0e, 8'h04};
      tw_tx(RW, 0);
      `CHK(acks[2:0], 3'b111)
      tx = '{8'h0e};
      tw_tx(RW, 2);
      `CHK({rx[0], rx[1]}, 16'h0400)
      for (int k = 0; k < 4; k++)
      begin
         rw(8'h0e, 8'(k * 2));
         `CHK({chg, fast}, {k[1], k[1] & k[0]})
      end
      tx = '{8'h1f, 8'hff, 8'h5a, 8'ha5, 8'h3c};
      tw_tx(MW, 0);
      `CHK(acks[5:0], 6'h3f)
      tx = '{8'h1f, 8'hff};
      tw_tx(MW, 2);
      `CHK({rx[0], rx[1]}, 16'h5aa5)
      tx = '{8'h02};
      tw_tx(RW, 1);
      tx = {};
      tw_tx(MW, 1);
      `CHK(rx[0], 8'h3c)
      for (int p = 0; p < 4; p++)
      begin
         rw(8'h0e, 8'(p << 3));
         for (int j = 0; j < 3; j++)
         begin
            tx = '{ends[j][15:8], ends[j][7:0], 8'(16 + p)};
            tw_tx(MW, 0);
            if (p <= j)
               shadow[j] = 8'(16 + p);
            `CHK(acks[3], 1'(p <= j))
            tx = '{ends[j][15:8], ends[j][7:0]};
            tw_tx(MW, 1);
            `CHK(rx[0], shadow[j])
         end
      end
      apb(1'b0, 8'h08, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b0, APB_STAT, 32'h0);
      `CHK(rd[23:22], 2'b11)
      apb(1'b1, APB_PWR, 32'h1);
      apb(1'b0, APB_STAT, 32'h0);
      `CHK({err, rd[23:21]}, 4'b0001)
      // the host reloads time once the backup flag shows.
      rw(8'h00, 8'h02);
      tx = '{8'h02, 8'h30, 8'h15, 8'h12};
      tw_tx(RW, 0);
      rw(8'h00, 8'h00);
      apb(1'b0, APB_STAT, 32'h0);
      `CHK({rd[19:14], rd[13:7], rd[6:0]}, {6'h12, 7'h15, 7'h30})
      // Lock, spoil the held seconds, then a snapshot must bring the core back.
      rw(8'h00, 8'h02);
      rw(8'h02, 8'h45);
      rw(8'h00, 8'h03);
      tx = '{8'h02};
      tw_tx(RW, 3);
      `CHK({rx[0], rx[1], rx[2]}, 24'h301512)
      // With only the snapshot bit set, a written value must not be overwritten.
      rw(8'h00, 8'h01);
      rw(8'h02, 8'h45);
      tx = '{8'h02};
      tw_tx(RW, 1);
      `CHK(rx[0], 8'h45)
      rw(8'h0e, 8'h20);
      for (int r = 1; r < 4; r++)
      begin
         rw(8'h00, 8'(r << 4));
         period();
         `CHK(c, per[r])
      end
      rw(8'h00, 8'h34);
      period();
      `CHK(c, 512)
      rw(8'h00, 8'h00);
      rw(8'h0e, 8'h00);
      repeat (8) @(posedge clk_i);
      `CHK(acs_n, 1'b1)
      complete_run();
   end
endmodule : test_rtcnv_core
